// File: inc/sdr_pkg.sv
package sdr_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int TICK_US      = 1000;
	localparam int TICK_CYC_DEF = TICK_US * CLK_MHZ;
	localparam int DISP_MS      = 2000;
	localparam int DISP_CYC_DEF = DISP_MS * 1000 * CLK_MHZ;

	// ------------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_SPD1     = 8'h04;
	localparam logic [7:0] OFS_SPD2     = 8'h08;
	localparam logic [7:0] OFS_SPD3     = 8'h0C;
	localparam logic [7:0] OFS_ACC      = 8'h10;
	localparam logic [7:0] OFS_DEC      = 8'h14;
	localparam logic [7:0] OFS_STAT     = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
	localparam logic [7:0] OFS_GAIN     = 8'h28;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_TUNE_LSB  = 4;
	localparam int STAT_MODE_LSB  = 2;
	localparam int STAT_ST_LSB    = 4;
	localparam int STAT_DROOP_LSB = 16;
	localparam int HTRANS_ACT_BIT = 1;

	// Control modes
	localparam logic [1:0] MODE_POS = 2'h0;
	localparam logic [1:0] MODE_SPD = 2'h1;

	// Interrupt bits
	localparam int IRQ_EMG  = 0;
	localparam int IRQ_ALM  = 1;
	localparam int IRQ_LIM  = 2;
	localparam int IRQ_SOFF = 3;
	localparam int IRQ_W    = 4;

	// Auto tuning
	localparam logic [15:0] TUNE_ERR_LIM = 16'h0010;
	localparam logic [7:0]  GAIN_RST     = 8'h40;
	localparam logic [7:0]  GAIN_MAX     = 8'hF0;
	localparam logic [7:0]  GAIN_MIN     = 8'h01;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  mode;
		logic [3:0]  tune;
		logic [15:0] spd1;
		logic [15:0] spd2;
		logic [15:0] spd3;
		logic [15:0] acc;
		logic [15:0] dec;
	} sdr_par_s;

	localparam sdr_par_s PAR_RST = '{
		mode: MODE_POS, tune: 4'h8,
		spd1: 16'h03E8, spd2: 16'h05DC, spd3: 16'h07D0,
		acc: 16'h0003, dec: 16'h0006};

	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [31:0] data;
	} sdr_wr_s;

endpackage : sdr_pkg

// File: hw/sdr_ahb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// AHB-Lite slave: zero-wait writes, one wait state on reads
// ----------------------------------------------------------------------
module sdr_ahb import sdr_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	output var  sdr_wr_s     wr,
	output var  logic [7:0]  rd_addr,
	input  wire logic [31:0] rd_data
);
	logic act_r;
	logic wr_r;
	logic [7:0] addr_r;

	// Address phase taken on an active transfer with hready
	wire acc = hsel & htrans[HTRANS_ACT_BIT] & hready;

	// Write strobe in the data phase, with hwdata
	assign wr.en   = act_r & wr_r;
	assign wr.addr = addr_r;
	assign wr.data = hwdata;
	assign rd_addr = addr_r;
	assign hresp   = 1'b0;

	// Registered read data: one wait state, clean hrdata
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_r     <= 1'b0;
			wr_r      <= 1'b0;
			addr_r    <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
		end else if (acc) begin
			act_r     <= 1'b1;
			wr_r      <= hwrite;
			addr_r    <= haddr[7:0];
			hreadyout <= hwrite;
		end else if (act_r & ~wr_r) begin
			hrdata    <= rd_data;
			hreadyout <= 1'b1;
			act_r     <= 1'b0;
		end else begin
			act_r     <= 1'b0;
		end
	end

endmodule : sdr_ahb
`default_nettype wire

// File: hw/sdr_ramp.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Speed ramp: separate accel and decel steps per tick
// ----------------------------------------------------------------------
module sdr_ramp import sdr_pkg::*; (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               tick,
	input  wire logic               sudden,
	input  wire logic signed [15:0] target,
	input  wire logic [15:0]        acc_step,
	input  wire logic [15:0]        dec_step,
	output var  logic signed [15:0] speed
);
	// Move toward target by one step, never past it
	function automatic logic signed [15:0] step_to(
		input logic signed [15:0] cur,
		input logic signed [15:0] tgt,
		input logic [15:0]        st
	);
		logic signed [16:0] nx;
		nx = 17'sh0_0000;
		if (cur < tgt) begin
			nx = cur + $signed({1'b0, st});
			if (nx > tgt)
				nx = tgt;
		end else begin
			nx = cur - $signed({1'b0, st});
			if (nx < tgt)
				nx = tgt;
		end
		return nx[15:0];
	endfunction : step_to

	// Growing magnitude uses accel step, shrinking decel step
	wire grow = (target > speed && speed >= 16'sh0000) ||
		(target < speed && speed <= 16'sh0000);
	wire [15:0] rate = grow ? acc_step : dec_step;

	// Sudden stop is a decel with zero time constant
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			speed <= 16'sh0000;
		else if (sudden)
			speed <= 16'sh0000;
		else if (tick && speed != target)
			speed <= step_to(speed, target, rate);
	end

endmodule : sdr_ramp
`default_nettype wire

// File: hw/sdr_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Servo drive run/stop sequencer
// ----------------------------------------------------------------------
// How it works
// - Power and servo-on give ready state, shaft locked.
// - Position mode: each command pulse becomes one step of rotation.
// - Servo-on off cuts power stage drive; motor coasts, no brake.
// - Alarm cuts drive, engages dynamic brake, sudden stop.
// - Emergency stop off: drive cut, dynamic brake, alarm raised.
// - Position mode limit off clears droop, locks; opposite motion allowed.
// - Speed mode: two select inputs pick a preset internal speed.
// - Forward start alone runs counter-clockwise, reverse alone clockwise.
// - Speed mode limit off: sudden stop, lock, opposite motion allowed.
// - Both starts on or both off: decelerate with configured decel.
// - Sudden stop means decel to standstill with zero time constant.
// - Power-on display shows mode symbol, then data after two seconds.
// - Parameter changes apply only after power off and on.
// - Gains adapt during run at the tuning response level.
module sdr_seq import sdr_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF,
	parameter int unsigned DISP_CYC = DISP_CYC_DEF
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output var  logic               hreadyout,
	output var  logic [31:0]        hrdata,
	output var  logic               hresp,
	input  wire logic               power_ok,
	input  wire logic               alarm_in,
	input  wire logic               servo_on_input,
	input  wire logic               emergency_stop_input,
	input  wire logic               forward_stroke_limit,
	input  wire logic               reverse_stroke_limit,
	input  wire logic               forward_start_input,
	input  wire logic               reverse_start_input,
	input  wire logic               speed_select_bit0,
	input  wire logic               speed_select_bit1,
	input  wire logic               cmd_pulse,
	input  wire logic               cmd_dir,
	output var  logic               power_stage_en,
	output var  logic               dyn_brake_en,
	output var  logic               servo_lock,
	output var  logic               emergency_stop_alarm,
	output var  logic               step_pulse,
	output var  logic               step_dir,
	output var  logic signed [15:0] speed_cmd,
	output var  logic [1:0]         disp_symbol,
	output var  logic               disp_data,
	output var  logic               irq
);
	typedef enum logic [1:0] {
		ST_PWROFF, ST_COAST, ST_RUN, ST_BRAKE
	} sdr_state_e;

	sdr_wr_s            wr;
	logic [7:0]         rd_addr;
	logic [31:0]        rd_data;
	sdr_par_s           pend_r;
	sdr_par_s           act_r;
	sdr_state_e         state_r;
	sdr_state_e         state_nxt;
	logic               pwr_d_r;
	logic               flim_d_r;
	logic               rlim_d_r;
	logic               emg_d_r;
	logic               alm_d_r;
	logic [31:0]        tick_cnt_r;
	logic               tick_r;
	logic [31:0]        disp_cnt_r;
	logic signed [15:0] droop_r;
	logic signed [15:0] droop_nxt;
	logic [7:0]         gain_r;
	logic [IRQ_W-1:0]   irq_stat_r;
	logic [IRQ_W-1:0]   irq_en_r;
	logic [IRQ_W-1:0]   irq_nxt;

	// Signed error magnitude, used by both modes
	function automatic logic [15:0] mag(input logic signed [15:0] v);
		return (v < 16'sh0000) ? 16'(-v) : 16'(v);
	endfunction : mag

	// ------------------------------------------------------------------
	// Bus slave and register access
	// ------------------------------------------------------------------
	sdr_ahb u_ahb (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.wr        (wr),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data)
	);

	// Write decode
	wire w_ctrl = wr.en & (wr.addr == OFS_CTRL);
	wire w_spd1 = wr.en & (wr.addr == OFS_SPD1);
	wire w_spd2 = wr.en & (wr.addr == OFS_SPD2);
	wire w_spd3 = wr.en & (wr.addr == OFS_SPD3);
	wire w_acc  = wr.en & (wr.addr == OFS_ACC);
	wire w_dec  = wr.en & (wr.addr == OFS_DEC);
	wire w_clr  = wr.en & (wr.addr == OFS_IRQ_CLR);
	wire w_en   = wr.en & (wr.addr == OFS_IRQ_EN);

	// Pending set: software reads what it wrote, not what runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r <= PAR_RST;
		end else begin
			if (w_ctrl) begin
				pend_r.mode <= wr.data[CTRL_MODE_LSB +: 2];
				pend_r.tune <= wr.data[CTRL_TUNE_LSB +: 4];
			end
			if (w_spd1)
				pend_r.spd1 <= wr.data[15:0];
			if (w_spd2)
				pend_r.spd2 <= wr.data[15:0];
			if (w_spd3)
				pend_r.spd3 <= wr.data[15:0];
			if (w_acc)
				pend_r.acc <= wr.data[15:0];
			if (w_dec)
				pend_r.dec <= wr.data[15:0];
		end
	end

	// Active set loads only on a power-on edge
	wire pwr_rise = power_ok & ~pwr_d_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			act_r <= PAR_RST;
		else if (pwr_rise)
			act_r <= pend_r;
	end

	// Read mux; unmapped offsets read zero
	wire [31:0] ctrl_rd = (32'(pend_r.mode) << CTRL_MODE_LSB) |
		(32'(pend_r.tune) << CTRL_TUNE_LSB);
	wire [31:0] stat_rd = (32'(16'(droop_r)) << STAT_DROOP_LSB) |
		(32'(state_r) << STAT_ST_LSB) |
		(32'(act_r.mode) << STAT_MODE_LSB) |
		32'(emergency_stop_alarm);
	assign rd_data =
		(rd_addr == OFS_CTRL)     ? ctrl_rd :
		(rd_addr == OFS_SPD1)     ? 32'(pend_r.spd1) :
		(rd_addr == OFS_SPD2)     ? 32'(pend_r.spd2) :
		(rd_addr == OFS_SPD3)     ? 32'(pend_r.spd3) :
		(rd_addr == OFS_ACC)      ? 32'(pend_r.acc) :
		(rd_addr == OFS_DEC)      ? 32'(pend_r.dec) :
		(rd_addr == OFS_STAT)     ? stat_rd :
		(rd_addr == OFS_IRQ_STAT) ? 32'(irq_stat_r) :
		(rd_addr == OFS_IRQ_EN)   ? 32'(irq_en_r) :
		(rd_addr == OFS_GAIN)     ? 32'(gain_r) :
		32'h0000_0000;

	// ------------------------------------------------------------------
	// Input history and tick divider
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_d_r  <= 1'b0;
			flim_d_r <= 1'b1;
			rlim_d_r <= 1'b1;
			emg_d_r  <= 1'b0;
			alm_d_r  <= 1'b0;
		end else begin
			pwr_d_r  <= power_ok;
			flim_d_r <= forward_stroke_limit;
			rlim_d_r <= reverse_stroke_limit;
			emg_d_r  <= ~emergency_stop_input;
			alm_d_r  <= alarm_in;
		end
	end

	// One-cycle tick enable for ramp and tuning
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b0;
		end else begin
			tick_r     <= (tick_cnt_r == TICK_CYC - 1);
			tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ?
				32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------------
	// Stop priority and run state
	// ------------------------------------------------------------------
	wire emg_stop  = ~emergency_stop_input;
	wire brake_req = alarm_in | emg_stop;
	wire lim_fall  = (flim_d_r & ~forward_stroke_limit) |
		(rlim_d_r & ~reverse_stroke_limit);

	// Brake exits to coast only with servo-on low: a cleared alarm
	// must never restart the motor
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_PWROFF: if (power_ok) state_nxt = ST_COAST;
			ST_COAST: if (servo_on_input) state_nxt = ST_RUN;
			ST_RUN: if (!servo_on_input) state_nxt = ST_COAST;
			ST_BRAKE: begin
				if (!brake_req && !servo_on_input)
					state_nxt = ST_COAST;
			end
			default: state_nxt = ST_PWROFF;
		endcase
		if (brake_req)
			state_nxt = ST_BRAKE;
		if (!power_ok)
			state_nxt = ST_PWROFF;
	end

	wire run_st  = (state_r == ST_RUN);
	wire run_pos = run_st & (act_r.mode == MODE_POS);
	wire run_spd = run_st & (act_r.mode == MODE_SPD);

	// ------------------------------------------------------------------
	// Position mode: droop counter and step output
	// ------------------------------------------------------------------
	wire pulse_ok = run_pos & cmd_pulse &
		(cmd_dir ? forward_stroke_limit : reverse_stroke_limit);
	wire step_go = run_pos & (droop_r != 16'sh0000) &
		((droop_r > 16'sh0000) ? forward_stroke_limit :
		reverse_stroke_limit);
	wire signed [15:0] d_in = ~pulse_ok ? 16'sh0000 :
		(cmd_dir ? 16'sh0001 : -16'sh0001);
	wire signed [15:0] d_out = ~step_go ? 16'sh0000 :
		((droop_r > 16'sh0000) ? 16'sh0001 : -16'sh0001);
	assign droop_nxt = (~run_pos | lim_fall) ? 16'sh0000 :
		droop_r + d_in - d_out;

	// ------------------------------------------------------------------
	// Speed mode: preset select, direction and stop patterns
	// ------------------------------------------------------------------
	wire [1:0] sel = {speed_select_bit1, speed_select_bit0};
	wire [15:0] sel_spd = (sel == 2'h1) ? act_r.spd1 :
		(sel == 2'h2) ? act_r.spd2 :
		(sel == 2'h3) ? act_r.spd3 : 16'h0000;
	wire fwd_only = forward_start_input & ~reverse_start_input;
	wire rev_only = reverse_start_input & ~forward_start_input;
	wire signed [15:0] target =
		(run_spd & fwd_only & forward_stroke_limit) ?
			$signed(sel_spd) :
		(run_spd & rev_only & reverse_stroke_limit) ?
			-$signed(sel_spd) : 16'sh0000;
	// Off limit blocks travel toward it; drive cut zeroes too
	wire sudden = ~run_spd |
		(~forward_stroke_limit & (speed_cmd > 16'sh0000)) |
		(~reverse_stroke_limit & (speed_cmd < 16'sh0000));

	sdr_ramp u_ramp (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.tick     (tick_r),
		.sudden   (sudden),
		.target   (target),
		.acc_step (act_r.acc),
		.dec_step (act_r.dec),
		.speed    (speed_cmd)
	);

	// ------------------------------------------------------------------
	// Interrupt status: set wins over clear
	// ------------------------------------------------------------------
	wire [IRQ_W-1:0] ev = IRQ_W'(
		(32'(emg_stop & ~emg_d_r) << IRQ_EMG) |
		(32'(alarm_in & ~alm_d_r) << IRQ_ALM) |
		(32'(lim_fall) << IRQ_LIM) |
		(32'(run_st & (state_nxt == ST_COAST)) << IRQ_SOFF));
	wire [IRQ_W-1:0] clr = w_clr ? wr.data[IRQ_W-1:0] : '0;
	assign irq_nxt = (irq_stat_r & ~clr) | ev;

	// ------------------------------------------------------------------
	// State, drive and status flops
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r              <= ST_PWROFF;
			droop_r              <= 16'sh0000;
			power_stage_en       <= 1'b0;
			dyn_brake_en         <= 1'b0;
			servo_lock           <= 1'b0;
			emergency_stop_alarm <= 1'b0;
			step_pulse           <= 1'b0;
			step_dir             <= 1'b0;
			irq_stat_r           <= '0;
			irq_en_r             <= '0;
			irq                  <= 1'b0;
		end else begin
			state_r              <= state_nxt;
			droop_r              <= droop_nxt;
			power_stage_en       <= (state_nxt == ST_RUN);
			dyn_brake_en         <= (state_nxt == ST_BRAKE);
			servo_lock           <= (state_nxt == ST_RUN) &
				(droop_nxt == 16'sh0000) &
				(target == 16'sh0000);
			emergency_stop_alarm <= power_ok & emg_stop;
			step_pulse           <= step_go;
			step_dir             <= (droop_r > 16'sh0000);
			irq_stat_r           <= irq_nxt;
			irq_en_r             <= w_en ? wr.data[IRQ_W-1:0] :
				irq_en_r;
			irq                  <= |(irq_nxt & irq_en_r);
		end
	end

	// ------------------------------------------------------------------
	// Real-time tuning and power-on display
	// ------------------------------------------------------------------
	wire [15:0] err = run_pos ? mag(droop_r) :
		mag(16'(target - speed_cmd));
	wire [7:0] gain_up = gain_r + {4'h0, act_r.tune};

	// Gain climbs by the tune level on large error and bleeds
	// off at zero error so it cannot ratchet to the ceiling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gain_r <= GAIN_RST;
		else if (tick_r & run_st & (err > TUNE_ERR_LIM))
			gain_r <= (gain_up > GAIN_MAX || gain_up < gain_r) ?
				GAIN_MAX : gain_up;
		else if (tick_r & run_st & (err == 16'h0000) &
			(gain_r > GAIN_MIN))
			gain_r <= gain_r - 8'h01;
	end

	// Symbol first, data after the delay; power loss restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			disp_cnt_r  <= 32'h0000_0000;
			disp_data   <= 1'b0;
			disp_symbol <= MODE_POS;
		end else begin
			disp_symbol <= act_r.mode;
			if (!power_ok) begin
				disp_cnt_r <= 32'h0000_0000;
				disp_data  <= 1'b0;
			end else if (disp_cnt_r != DISP_CYC) begin
				disp_cnt_r <= disp_cnt_r + 32'h0000_0001;
				disp_data  <= (disp_cnt_r == DISP_CYC - 1);
			end
		end
	end

endmodule : sdr_seq
`default_nettype wire

// File: sim/sdr_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks of the sequencer
// ----------------------------------------------------------------
module sdr_seq_assertions import sdr_pkg::*; #(
	parameter int unsigned DISP_CYC = DISP_CYC_DEF
) (
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               hsel,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic               hready,
	input wire logic               hreadyout,
	input wire logic               power_ok,
	input wire logic               alarm_in,
	input wire logic               servo_on_input,
	input wire logic               emergency_stop_input,
	input wire logic               forward_stroke_limit,
	input wire logic               power_stage_en,
	input wire logic               dyn_brake_en,
	input wire logic               servo_lock,
	input wire logic               emergency_stop_alarm,
	input wire logic               step_pulse,
	input wire logic               step_dir,
	input wire logic signed [15:0] speed_cmd,
	input wire logic               disp_data
);
	// Display delay window; wider would hide slips
	localparam int DLO = DISP_CYC - 2;
	localparam int DHI = DISP_CYC + 2;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read request, power-up and fault sequences
	sequence s_rd_req;
		hsel && htrans[1] && !hwrite && hready;
	endsequence
	sequence s_pwr_up;
		$rose(power_ok) ##1 !disp_data;
	endsequence
	sequence s_fault;
		power_ok && (alarm_in || !emergency_stop_input);
	endsequence
	a_read_wait: assert property (s_rd_req |=> !hreadyout ##1 hreadyout)
		else $error("read wait");
	a_fault_brake: assert property (s_fault |=> dyn_brake_en && !power_stage_en)
		else $error("no brake");
	a_emg_alarm: assert property (power_ok && !emergency_stop_input |=> emergency_stop_alarm)
		else $error("no alarm");
	a_coast_free: assert property (power_ok && !alarm_in && emergency_stop_input
		&& !servo_on_input && !dyn_brake_en |=> !power_stage_en && !dyn_brake_en)
		else $error("no coast");
	a_lock_run: assert property (servo_lock |-> power_stage_en)
		else $error("lock no drive");
	a_fwd_drop: assert property (!forward_stroke_limit [*3] |-> !(step_pulse && step_dir))
		else $error("step to limit");
	a_disp_delay: assert property (s_pwr_up |-> ##[DLO:DHI] disp_data)
		else $error("display delay");
	a_stop_zero: assert property ($fell(power_stage_en) |=> speed_cmd == 16'sh0000)
		else $error("stop not sudden");
	a_limit_stop: assert property (!forward_stroke_limit && speed_cmd > 0 |=> speed_cmd == 0)
		else $error("limit stop");
endmodule : sdr_seq_assertions
bind sdr_seq sdr_seq_assertions #(.DISP_CYC(DISP_CYC)) chk_u (.*);
`default_nettype wire

// File: sim/sdr_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Positioning device: bursts of command pulses
// ----------------------------------------------------------------
module sdr_pulse_src (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       pulse_go,
	input wire logic       pulse_dir,
	input wire logic [3:0] pulse_n,
	input wire logic [1:0] pulse_gap,
	output var logic       cmd_pulse,
	output var logic       cmd_dir,
	output var logic       pulse_busy
);
	logic [3:0] left_r;
	logic [1:0] gap_r;
	assign pulse_busy = left_r != 4'h0;
	// Gap 0 gives back-to-back pulses; dir toggles when idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{left_r, gap_r, cmd_pulse, cmd_dir} <= '0;
		end else begin
			cmd_pulse <= 1'b0;
			if (pulse_go && !pulse_busy) begin
				{left_r, gap_r, cmd_dir} <= {pulse_n, pulse_gap, pulse_dir};
			end else if (pulse_busy && gap_r == 2'h0) begin
				cmd_pulse <= 1'b1;
				left_r    <= left_r - 4'h1;
				gap_r     <= pulse_gap;
			end else if (pulse_busy) begin
				gap_r <= gap_r - 2'h1;
			end else begin
				cmd_dir <= ~cmd_dir;
			end
		end
	end
endmodule : sdr_pulse_src
`default_nettype wire

// File: sim/sdr_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
// ----------------------------------------------------------------
// Self-checking bench of the sequencer
// ----------------------------------------------------------------
module sdr_seq_bench import sdr_pkg::*;;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, pulse_gap = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic power_ok = 1'b0, alarm_in = 1'b0, servo_on_input = 1'b0;
	logic emergency_stop_input = 1'b1, forward_stroke_limit = 1'b1;
	logic reverse_stroke_limit = 1'b1, forward_start_input = 1'b0;
	logic reverse_start_input = 1'b0, speed_select_bit0 = 1'b0;
	logic speed_select_bit1 = 1'b0, pulse_go = 1'b0, pulse_dir = 1'b0;
	logic [3:0] pulse_n = 4'h0;
	logic hreadyout, hresp, cmd_pulse, cmd_dir, pulse_busy, power_stage_en;
	logic dyn_brake_en, servo_lock, emergency_stop_alarm, step_pulse;
	logic step_dir, disp_data, irq;
	logic [1:0] disp_symbol;
	logic signed [15:0] speed_cmd;
	logic signed [15:0] sv [3];
	wire logic hready = hreadyout;
	logic [31:0] seed = 32'hf5c2_9185;
	int mismatches = 0, n_checks = 0, nf = 0, nr = 0, ef = 0, er = 0;
	logic [7:0] ra [6] = '{OFS_CTRL, OFS_SPD1, OFS_DEC, OFS_IRQ_EN,
		OFS_GAIN, 8'h2C};
	logic [31:0] re [6] = '{32'h0000_0080, 32'h0000_03E8, 32'h0000_0006,
		32'h0000_0000, 32'h0000_0040, 32'h0000_0000};

	sdr_seq #(.TICK_CYC(4), .DISP_CYC(20)) dut_u (.*);
	sdr_pulse_src host_u (.*);

	// Clock; steps counted off the edge
	initial forever #5 hclk = ~hclk;
	always @(negedge hclk) if (step_pulse === 1'b1) begin
		if (step_dir) nf++;
		else nr++;
	end

	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function logic signed [15:0] want(input int k);
		if (k == 0) return 16'sh0000;
		return k[0] ? -sv[k-1] : sv[k-1];
	endfunction : want

	task at(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask : at

	// Ready read mid-cycle, never raced
	task rdy();
		logic r;
		do begin
			@(negedge hclk);
			r = hreadyout;
			q = hrdata;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask : rdy

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h00_0000, a};
		rdy();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		rdy();
	endtask : bus

	task burst(input logic d, input logic ok);
		seed = xs(seed);
		@(posedge hclk);
		{pulse_go, pulse_dir, pulse_gap} <= {1'b1, d, seed[4:3]};
		pulse_n <= {1'b0, seed[2:0]} + 4'h1;
		if (ok && d) ef += int'(seed[2:0]) + 1;
		if (ok && !d) er += int'(seed[2:0]) + 1;
		@(posedge hclk);
		pulse_go <= 1'b0;
		at(48);
		`CK(nf, ef)
		`CK(nr, er)
	endtask : burst

	task complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// Watchdog: tests need about 1600 cycles
	initial begin
		#100_000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0000_0000);
			`CK(q, re[i])
		end
		power_ok <= 1'b1;
		at(15);
		`CK({disp_symbol, disp_data}, {MODE_POS, 1'b0})
		at(10);
		`CK(disp_data, 1'b1)
		$display("power-on done");
		@(posedge hclk);
		servo_on_input <= 1'b1;
		at(3);
		`CK(servo_lock & power_stage_en, 1'b1)
		burst(1'b1, 1'b1);
		burst(1'b0, 1'b1);
		bus(1'b1, OFS_IRQ_EN, 32'h0000_0001 << IRQ_LIM);
		forward_stroke_limit <= 1'b0;
		at(3);
		`CK({irq, servo_lock}, 2'b11)
		burst(1'b1, 1'b0);
		burst(1'b0, 1'b1);
		bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001 << IRQ_LIM);
		at(2);
		`CK(irq, 1'b0)
		bus(1'b1, OFS_IRQ_EN, 32'h0000_0000);
		{forward_stroke_limit, servo_on_input} <= 2'b10;
		at(2);
		`CK({power_stage_en, dyn_brake_en, irq}, 3'b000)
		bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
		`CK(q[IRQ_SOFF], 1'b1)
		$display("position mode done");
		// Presets stay pending until power cycles
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			sv[i] = 16'sd20 + 16'(seed[4:0]);
			bus(1'b1, 8'(OFS_SPD1 + 4 * i), 32'(sv[i]));
		end
		bus(1'b1, OFS_CTRL, 32'h0000_0081);
		bus(1'b0, OFS_STAT, 32'h0000_0000);
		`CK(q[3:2], MODE_POS)
		power_ok <= 1'b0;
		at(2);
		@(posedge hclk);
		power_ok <= 1'b1;
		at(3);
		`CK(disp_symbol, MODE_SPD)
		servo_on_input <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge hclk);
			{speed_select_bit1, speed_select_bit0} <= k[1:0];
			{forward_start_input, reverse_start_input} <= {!k[0], k[0]};
			at(200);
			`CK(speed_cmd, want(k))
		end
		forward_start_input <= 1'b1;
		at(2);
		`CK(speed_cmd == 16'sh0000, 1'b0)
		at(60);
		`CK(speed_cmd, 16'sh0000)
		reverse_start_input <= 1'b0;
		at(200);
		forward_stroke_limit <= 1'b0;
		at(2);
		`CK({speed_cmd == 16'sh0000, power_stage_en}, 2'b11)
		{forward_start_input, reverse_start_input} <= 2'b01;
		at(200);
		`CK(speed_cmd, -sv[2])
		$display("speed mode done");
		bus(1'b1, OFS_IRQ_EN, 32'h0000_0001 << IRQ_ALM);
		alarm_in <= 1'b1;
		at(2);
		`CK({dyn_brake_en, power_stage_en, speed_cmd == 0}, 3'b101)
		`CK(irq, 1'b1)
		{alarm_in, emergency_stop_input} <= 2'b00;
		at(2);
		`CK({emergency_stop_alarm, dyn_brake_en}, 2'b11)
		{emergency_stop_input, servo_on_input} <= 2'b10;
		at(2);
		`CK({dyn_brake_en, power_stage_en}, 2'b00)
		$display("fault stops done");
		complete_run();
	end
endmodule : sdr_seq_bench
`default_nettype wire
